// *** cio_pkg.sv ***
/*
 * Shared constants for the custom I/O conditioner: channel counts, register map,
 * field positions, reset values, tick timing, chopping durations and state types.
 * Assumes a 200 MHz system clock; all timing is counted in 100 us ticks.
 */
package cio_pkg;
    localparam int N_IN     = 8;
    localparam int N_OUT    = 8;
    localparam int N_VIN    = 16;
    localparam int N_VOUT   = 16;
    localparam int SEL_W    = 4;
    localparam int CNT_W    = 16;
    localparam int CLK_MHZ  = 200;
    localparam int TICK_US  = 100;
    localparam int MS_US    = 1000;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;

    // Register byte addresses
    localparam logic [11:0] IN_CFG_BASE = 12'h000;
    localparam logic [11:0] OUT_BASE    = 12'h080;
    localparam logic [11:0] STATUS_OFS  = 12'h100;
    localparam logic [11:0] VSTAT_OFS   = 12'h104;
    // Word index inside one 16-byte output channel block
    localparam logic [1:0]  OW_CFG  = 2'h0;
    localparam logic [1:0]  OW_DLY  = 2'h1;
    localparam logic [1:0]  OW_HOLD = 2'h2;
    localparam logic [1:0]  OW_MAN  = 2'h3;

    // Field positions
    localparam int IN_INV_BIT  = 0;
    localparam int IN_TOG_BIT  = 1;
    localparam int IN_SEL_LSB  = 4;
    localparam int OUT_TOG_BIT = 0;
    localparam int ON_EN_BIT   = 1;
    localparam int OFF_EN_BIT  = 2;
    localparam int OUT_INV_BIT = 3;
    localparam int OUT_SEL_LSB = 4;
    localparam int CHOP_LSB    = 8;

    // Reset values
    localparam logic [7:0]  IN_CFG_RST  = 8'h00;
    localparam logic [15:0] OUT_CFG_RST = 16'h0000;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;

    // Chopping durations in ticks
    localparam logic [CNT_W-1:0] T_2MS  = CNT_W'(2 * MS_US / TICK_US);
    localparam logic [CNT_W-1:0] T_4MS  = CNT_W'(4 * MS_US / TICK_US);
    localparam logic [CNT_W-1:0] T_8MS  = CNT_W'(8 * MS_US / TICK_US);
    localparam logic [CNT_W-1:0] T_10MS = CNT_W'(10 * MS_US / TICK_US);
    localparam logic [CNT_W-1:0] T_22MS = CNT_W'(22 * MS_US / TICK_US);

    typedef enum logic [3:0] {
        CHOP_FULL = 4'h0, CHOP_8_4 = 4'h1, CHOP_4_2 = 4'h2, CHOP_4_4 = 4'h3,
        CHOP_2_2  = 4'h4, CHOP_2_4 = 4'h5, CHOP_2_10 = 4'h6, CHOP_2_22 = 4'h7,
        CHOP_MAN  = 4'h8
    } cio_chop_type;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00, CH_HOLD = 2'b01, CH_ON = 2'b11, CH_OFF = 2'b10
    } cio_chst_type;
endpackage

// *** cio_out_chan.sv ***
/*
 * One output conditioning chain: mode, ON delay, OFF delay, polarity, chopping.
 * Assumes a one-cycle tick_i every 100 us and stable configuration inputs.
 */
`timescale 1ns/1ps
module cio_out_chan
    import cio_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             tick_i,
    input  wire logic             src_i,
    input  wire logic [15:0]      cfg_i,
    input  wire logic [31:0]      dly_i,
    input  wire logic [CNT_W-1:0] hold_i,
    input  wire logic [31:0]      man_i,
    output logic                  pin_o
);
    logic             prev_src, tog, on_q, off_q, pin, mode_q, pol_q;
    logic             next_prev_src, next_tog, next_on_q, next_off_q, next_pin;
    logic [CNT_W-1:0] on_cnt, off_cnt, ch_cnt, on_t, off_t;
    logic [CNT_W-1:0] next_on_cnt, next_off_cnt, next_ch_cnt;
    logic [3:0]       chop;
    cio_chst_type     ch_st, next_ch_st;

    assign pin_o = pin;
    assign chop  = cfg_i[CHOP_LSB +: 4];

    always_comb begin
        next_prev_src = src_i;
        next_tog = tog ^ (src_i & ~prev_src);
        mode_q = cfg_i[OUT_TOG_BIT] ? tog : src_i;
        next_on_cnt = on_cnt;
        next_on_q = on_q;
        if (!cfg_i[ON_EN_BIT] || !mode_q) begin
            next_on_q = cfg_i[ON_EN_BIT] ? 1'b0 : mode_q;
            next_on_cnt = '0;
        end else if (!on_q) begin
            if (on_cnt >= dly_i[15:0])
                next_on_q = 1'b1;
            else if (tick_i)
                next_on_cnt = on_cnt + 1'b1;
        end
        next_off_cnt = off_cnt;
        next_off_q = off_q;
        if (!cfg_i[OFF_EN_BIT] || on_q) begin
            next_off_q = on_q;
            next_off_cnt = '0;
        end else if (off_q) begin
            if (off_cnt >= dly_i[31:16])
                next_off_q = 1'b0;
            else if (tick_i)
                next_off_cnt = off_cnt + 1'b1;
        end
        pol_q = off_q ^ cfg_i[OUT_INV_BIT];
        case (chop)
            CHOP_8_4:  begin on_t = T_8MS; off_t = T_4MS;  end
            CHOP_4_2:  begin on_t = T_4MS; off_t = T_2MS;  end
            CHOP_4_4:  begin on_t = T_4MS; off_t = T_4MS;  end
            CHOP_2_2:  begin on_t = T_2MS; off_t = T_2MS;  end
            CHOP_2_4:  begin on_t = T_2MS; off_t = T_4MS;  end
            CHOP_2_10: begin on_t = T_2MS; off_t = T_10MS; end
            CHOP_2_22: begin on_t = T_2MS; off_t = T_22MS; end
            CHOP_MAN:  begin on_t = man_i[15:0]; off_t = man_i[31:16]; end
            default:   begin on_t = '0; off_t = '0; end
        endcase
        next_ch_st = ch_st;
        next_ch_cnt = tick_i ? ch_cnt + 1'b1 : ch_cnt;
        next_pin = 1'b1;
        if (chop == CHOP_FULL || chop > CHOP_MAN || !pol_q) begin
            next_ch_st = CH_IDLE;
            next_ch_cnt = '0;
            next_pin = pol_q;
        end else begin
            case (ch_st)
                CH_IDLE: begin
                    next_ch_st = CH_HOLD;
                    next_ch_cnt = '0;
                end
                CH_HOLD: if (ch_cnt >= hold_i) begin
                    next_ch_st = CH_ON;
                    next_ch_cnt = '0;
                end
                CH_ON: if (ch_cnt >= on_t) begin
                    next_ch_st = CH_OFF;
                    next_ch_cnt = '0;
                    next_pin = 1'b0;
                end
                CH_OFF: if (ch_cnt >= off_t) begin
                    next_ch_st = CH_ON;
                    next_ch_cnt = '0;
                end else begin
                    next_pin = 1'b0;
                end
                default: next_ch_st = CH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_src <= 1'b0;
            tog      <= 1'b0;
            on_q     <= 1'b0;
            off_q    <= 1'b0;
            on_cnt   <= '0;
            off_cnt  <= '0;
            ch_cnt   <= '0;
            ch_st    <= CH_IDLE;
            pin      <= 1'b0;
        end else begin
            prev_src <= next_prev_src;
            tog      <= next_tog;
            on_q     <= next_on_q;
            off_q    <= next_off_q;
            on_cnt   <= next_on_cnt;
            off_cnt  <= next_off_cnt;
            ch_cnt   <= next_ch_cnt;
            ch_st    <= next_ch_st;
            pin      <= next_pin;
        end
    end

    default clocking oc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    out_tog_flip_a: assert property ((src_i && !prev_src) |=> tog != $past(tog))
        else $error("output toggle did not flip on rise");
    on_pass_a: assert property (!cfg_i[ON_EN_BIT] |=> on_q == $past(mode_q))
        else $error("disabled ON delay altered signal");
    on_wait_a: assert property ((cfg_i[ON_EN_BIT] && !on_q ##1 on_q) |->
        $past(on_cnt) >= $past(dly_i[15:0])) else $error("ON delay ended early");
    off_pass_a: assert property (!cfg_i[OFF_EN_BIT] |=> off_q == $past(on_q))
        else $error("disabled OFF delay altered signal");
    chop_full_a: assert property ((chop == CHOP_FULL) |=> pin == $past(pol_q))
        else $error("full duty did not forward input");
    chop_on_a: assert property ((ch_st == CH_ON ##1 ch_st == CH_OFF) |->
        $past(ch_cnt) >= $past(on_t)) else $error("chop on phase too short");
    rst_clear_a: assert property ($past(rst_i) |-> !tog && !on_q && !off_q)
        else $error("stage state not cleared by reset");
endmodule // cio_out_chan

// *** cio_top.sv ***
/*
 * Custom I/O conditioner top: Wishbone classic register slave, input polarity and
 * toggle stages, physical-to-virtual input routing, virtual-to-physical output
 * routing, the 100 us tick and one output chain per physical output.
 * Assumes all pins are synchronous to clk_i and a single-cycle classic master.
 */
// Local design decisions: the register offsets and register access over Wishbone.
//
// Summary of operation
// - Input path is polarity then mode, result stored in its physical slot.
// - Input polarity straight passes signal; invert passes its complement.
// - Input pass-through mode forwards the polarity result unchanged.
// - Input toggle mode flips its output on every rising edge, starting low.
// - Each physical slot drives one software-selected virtual function input.
// - Each physical output takes one software-selected virtual function output.
// - Output path is mode, ON delay, OFF delay, polarity, chopping, then pin.
// - Output mode passes through, or flips on every rising edge.
// - Enabled ON delay postpones each rise by count times 100 us.
// - Enabled OFF delay postpones each fall by count times 100 us.
// - Output polarity forwards straight or complemented OFF delay result.
// - Chopping holds solid high for a count, then pulses; full duty passes.
// - Duty choices: 8/4, 4/2, 4/4, 2/2, 2/4, 2/10, 2/22 ms, full, manual.
`timescale 1ns/1ps
module cio_top
    import cio_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [31:0]       adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    input  wire logic [N_IN-1:0]   ext_in_i,
    output logic      [N_VIN-1:0]  virt_in_o,
    input  wire logic [N_VOUT-1:0] virt_out_i,
    output logic      [N_OUT-1:0]  pin_o
);
    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES_P - 1);

    logic [CNT_W-1:0] tick_cnt, next_tick_cnt;
    logic             tick;

    logic             ack, next_ack;
    logic [31:0]      rdat, next_rdat;
    logic             upper_ok, in_hit, out_hit, wr_go;
    logic [11:0]      adr;
    logic [2:0]       in_idx, out_idx;
    logic [1:0]       ow;
    logic [31:0]      wmask;

    logic [7:0]       in_cfg   [N_IN];
    logic [7:0]       next_in_cfg [N_IN];
    logic [15:0]      out_cfg  [N_OUT];
    logic [15:0]      next_out_cfg [N_OUT];
    logic [31:0]      out_dly  [N_OUT];
    logic [31:0]      next_out_dly [N_OUT];
    logic [CNT_W-1:0] out_hold [N_OUT];
    logic [CNT_W-1:0] next_out_hold [N_OUT];
    logic [31:0]      out_man  [N_OUT];
    logic [31:0]      next_out_man [N_OUT];

    logic [N_IN-1:0]  pol, pol_prev, next_pol_prev;
    logic [N_IN-1:0]  tog, next_tog, phys, next_phys;
    logic [N_VIN-1:0] vin, next_vin;
    logic [N_OUT-1:0] chan_src, chan_pin;

    assign dat_o     = rdat;
    assign ack_o     = ack;
    assign virt_in_o = vin;
    assign pin_o     = chan_pin;

    always_comb begin
        tick = (tick_cnt == TICK_LAST);
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            tick_cnt <= '0;
        else
            tick_cnt <= next_tick_cnt;
    end

    // Address decode; anything outside the map reads zero and ignores writes
    always_comb begin
        adr      = adr_i[11:0];
        upper_ok = (adr_i[31:12] == 20'h00000);
        in_hit   = upper_ok && (adr[11:5] == IN_CFG_BASE[11:5]);
        out_hit  = upper_ok && (adr[11:7] == OUT_BASE[11:7]);
        in_idx   = adr[4:2];
        out_idx  = adr[6:4];
        ow       = adr[3:2];
        wmask    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        // Write lands on the edge where the master sees ack
        wr_go    = cyc_i && stb_i && we_i && ack;
    end

    // Bus answer and read data
    always_comb begin
        next_ack  = cyc_i && stb_i && !ack;
        next_rdat = WORD_RST;
        if (in_hit) begin
            next_rdat = {24'h000000, in_cfg[in_idx]};
        end else if (out_hit) begin
            case (ow)
                OW_CFG:  next_rdat = {16'h0000, out_cfg[out_idx]};
                OW_DLY:  next_rdat = out_dly[out_idx];
                OW_HOLD: next_rdat = {16'h0000, out_hold[out_idx]};
                OW_MAN:  next_rdat = out_man[out_idx];
                default: next_rdat = WORD_RST;
            endcase
        end else if (upper_ok && adr == STATUS_OFS) begin
            next_rdat = {16'h0000, chan_pin, phys};
        end else if (upper_ok && adr == VSTAT_OFS) begin
            next_rdat = {virt_out_i, vin};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack  <= 1'b0;
            rdat <= WORD_RST;
        end else begin
            ack  <= next_ack;
            rdat <= next_rdat;
        end
    end

    // Configuration registers with byte enables
    always_comb begin
        for (int i = 0; i < N_IN; i++) begin
            next_in_cfg[i] = in_cfg[i];
            if (wr_go && in_hit && in_idx == 3'(i))
                next_in_cfg[i] = (in_cfg[i] & ~wmask[7:0]) | (dat_i[7:0] & wmask[7:0]);
        end
        for (int j = 0; j < N_OUT; j++) begin
            next_out_cfg[j]  = out_cfg[j];
            next_out_dly[j]  = out_dly[j];
            next_out_hold[j] = out_hold[j];
            next_out_man[j]  = out_man[j];
            if (wr_go && out_hit && out_idx == 3'(j)) begin
                case (ow)
                    OW_CFG:  next_out_cfg[j] = (out_cfg[j] & ~wmask[15:0])
                                             | (dat_i[15:0] & wmask[15:0]);
                    OW_DLY:  next_out_dly[j] = (out_dly[j] & ~wmask) | (dat_i & wmask);
                    OW_HOLD: next_out_hold[j] = (out_hold[j] & ~wmask[15:0])
                                              | (dat_i[15:0] & wmask[15:0]);
                    OW_MAN:  next_out_man[j] = (out_man[j] & ~wmask) | (dat_i & wmask);
                    default: next_out_man[j] = out_man[j];
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < N_IN; i++)
                in_cfg[i] <= IN_CFG_RST;
            for (int j = 0; j < N_OUT; j++) begin
                out_cfg[j]  <= OUT_CFG_RST;
                out_dly[j]  <= WORD_RST;
                out_hold[j] <= '0;
                out_man[j]  <= WORD_RST;
            end
        end else begin
            in_cfg   <= next_in_cfg;
            out_cfg  <= next_out_cfg;
            out_dly  <= next_out_dly;
            out_hold <= next_out_hold;
            out_man  <= next_out_man;
        end
    end

    // Input conditioning
    always_comb begin
        next_vin = '0;
        for (int i = 0; i < N_IN; i++) begin
            pol[i] = ext_in_i[i] ^ in_cfg[i][IN_INV_BIT];
            next_tog[i] = tog[i] ^ (pol[i] & ~pol_prev[i]);
            next_phys[i] = in_cfg[i][IN_TOG_BIT] ? next_tog[i] : pol[i];
            // slot drives its selected virtual input
            if (phys[i])
                next_vin[in_cfg[i][IN_SEL_LSB +: SEL_W]] = 1'b1;
        end
        next_pol_prev = pol;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pol_prev <= '0;
            tog      <= '0;
            phys     <= '0;
            vin      <= '0;
        end else begin
            pol_prev <= next_pol_prev;
            tog      <= next_tog;
            phys     <= next_phys;
            vin      <= next_vin;
        end
    end

    always_comb begin
        for (int j = 0; j < N_OUT; j++)
            chan_src[j] = virt_out_i[out_cfg[j][OUT_SEL_LSB +: SEL_W]];
    end

    for (genvar g = 0; g < N_OUT; g++) begin : g_out
        cio_out_chan u_chan (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .tick_i (tick),
            .src_i  (chan_src[g]),
            .cfg_i  (out_cfg[g]),
            .dly_i  (out_dly[g]),
            .hold_i (out_hold[g]),
            .man_i  (out_man[g]),
            .pin_o  (chan_pin[g])
        );
    end

    default clocking tc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    wb_ack_once_a: assert property ((cyc_i && stb_i && !ack) |=> ack ##1 !ack)
        else $error("ack not a single cycle pulse");
    wb_cfg_write_a: assert property ((wr_go && out_hit && out_idx == 3'h0 && ow == OW_CFG
        && sel_i == 4'hF) |=> out_cfg[0] == $past(dat_i[15:0]))
        else $error("output config write lost");
    in_straight_a: assert property ((in_cfg[0][1:0] == 2'b00)
        |=> phys[0] == $past(ext_in_i[0])) else $error("straight input mismatch");
    in_invert_a: assert property ((in_cfg[0][1:0] == 2'b01)
        |=> phys[0] == !$past(ext_in_i[0])) else $error("inverted input mismatch");
    in_toggle_a: assert property ((in_cfg[0][IN_TOG_BIT] && pol[0] && !pol_prev[0])
        |=> phys[0] == !$past(tog[0]) && tog[0] == phys[0])
        else $error("input toggle did not flip");
    in_tog_hold_a: assert property ((in_cfg[0][IN_TOG_BIT] && !(pol[0] && !pol_prev[0]))
        |=> phys[0] == $past(tog[0])) else $error("input toggle moved without rise");
    vin_route_a: assert property (phys[0]
        |=> vin[$past(in_cfg[0][IN_SEL_LSB +: SEL_W])]) else $error("virtual input not driven");
    tick_gap_a: assert property (tick |=> !tick [*8])
        else $error("tick too frequent");
    tick_due_a: assert property ((tick_cnt == TICK_LAST - 1'b1) |=> tick)
        else $error("tick late");
endmodule // cio_top

// *** cio_partner.sv ***
/*
 * Far-side model: a bank of on/off switches feeding ext_in_i and a row of
 * solenoid coils loading pin_o. Assumes set_sw is called just after a rising edge.
 */
`timescale 1ns/1ps
module cio_partner
    import cio_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic [N_OUT-1:0] pin_i,
    output logic      [N_IN-1:0]  ext_o,
    output logic      [15:0]      rises_o
);
    logic [N_OUT-1:0] pin_q;

    initial begin
        ext_o = '0;
        pin_q = '0;
        rises_o = '0;
    end

    // Contacts change in the time step of the call; the task itself waits for no clock edge
    task automatic set_sw(input logic [N_IN-1:0] v);
        ext_o <= v;
    endtask

    // Coil meter: counts energising edges on all coils
    always @(posedge clk_i) begin
        pin_q <= pin_i;
        rises_o <= rises_o + 16'($countones(pin_i & ~pin_q));
    end
endmodule // cio_partner

// *** cio_top_tb_top.sv ***
/*
 * Self-checking bench for cio_top: Wishbone reads queue their expected value,
 * a posedge monitor compares at the edge where ack_o is sampled high.
 * Tick shortened to 10 cycles.
 */
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp); end end
module cio_top_tb_top;
    import cio_pkg::*;
    localparam int TP = 10;
    localparam int MSC = TP * 10;
    localparam int LIMIT = 40000;
    logic        clk_i, rst_i, cyc, stb, we, ack_o;
    logic [31:0] adr, dat, dat_o;
    logic [3:0]  sel;
    logic [7:0]  ext, pin;
    logic [15:0] vin, vout, rises;
    logic [31:0] exp_q[$], msk_q[$];
    int          n_mismatch, comparisons, cyc_n, t0;
    int          seed = 32'h7DB2;

    cio_top #(.TICK_CYCLES_P(TP)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .ext_in_i(ext), .virt_in_o(vin), .virt_out_i(vout), .pin_o(pin));
    cio_partner sw (.clk_i(clk_i), .pin_i(pin), .ext_o(ext), .rises_o(rises));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d coil rises %0d", comparisons, n_mismatch, rises);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // Read data is taken at the same rising edge at which the master sees ack
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected read")
            else begin
                `CHK(dat_o & msk_q[0], exp_q[0], "read data")
                void'(exp_q.pop_front());
                void'(msk_q.pop_front());
            end
        end
    end

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) `CHK(1'b0, 1'b1, "no ack")
        // Release at the ack edge itself; the next call idles one cycle first
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        bus(a, 1'b0, 32'h0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic at(input int t);
        while (cyc_n - t0 < t) @(posedge clk_i);
    endtask

    initial begin
        int          on_ms[9];
        int          off_ms[9];
        logic [31:0] c;
        logic [15:0] exp_v;
        logic [7:0]  e, inv, exp8;
        logic [3:0]  s;
        on_ms = '{0, 8, 4, 4, 2, 2, 2, 2, 2};
        off_ms = '{0, 4, 2, 4, 2, 4, 10, 22, 2};
        {cyc, stb, we, adr, dat, vout, n_mismatch, comparisons, cyc_n} = '0;
        sel = 4'hF;
        rst_i = 1'b1;
        tick(5);
        rst_i <= 1'b0;
        rd(32'h100, 32'h0, 32'hFFFF);
        rd(32'h104, 32'h0, 32'hFFFF_FFFF);
        rd(32'h080, 32'h0, 32'hFFF);
        rd(32'h200, 32'h0, 32'hFFFF_FFFF);
        $display("test reset done");
        wr(32'h000, 32'h2);
        wr(32'h080, 32'h1);
        for (int k = 0; k < 4; k++) begin
            sw.set_sw(8'h01);
            vout <= 16'h1;
            tick(4);
            sw.set_sw(8'h00);
            vout <= 16'h0;
            tick(6);
            rd(32'h100, {23'h0, ~k[0], 7'h0, ~k[0]}, 32'h101);
        end
        $display("test toggle done");
        for (int r = 0; r < 3; r++) begin
            c = $random(seed);
            e = c[7:0];
            inv = c[15:8];
            exp_v = '0;
            for (int i = 0; i < 8; i++) begin
                c = $random(seed);
                s = c[3:0];
                wr(32'(4 * i), {24'h0, s, 3'b000, inv[i]});
                if (e[i] ^ inv[i]) exp_v[s] = 1'b1;
            end
            sw.set_sw(e);
            tick(3);
            rd(32'h100, {24'h0, e ^ inv}, 32'hFF);
            rd(32'h104, {16'h0, exp_v}, 32'hFFFF);
            `CHK(vin, exp_v, "virtual input pins")
        end
        $display("test input routing done");
        for (int r = 0; r < 2; r++) begin
            c = $random(seed);
            vout <= c[15:0];
            exp_v = c[15:0];
            for (int j = 0; j < 8; j++) begin
                c = $random(seed);
                wr(32'h080 + 32'(16 * j), {24'h0, c[7:4], c[3], 3'b000});
                exp8[j] = exp_v[c[7:4]] ^ c[3];
            end
            tick(5);
            rd(32'h100, {16'h0, exp8, 8'h0}, 32'hFF00);
        end
        $display("test output routing done");
        vout <= 16'h0;
        wr(32'h090, 32'h0000_0016);
        wr(32'h094, {16'd8, 16'd5});
        tick(10);
        vout <= 16'h2;
        t0 = cyc_n;
        at(20);
        rd(32'h100, 32'h0, 32'h200);
        at(65);
        rd(32'h100, 32'h200, 32'h200);
        vout <= 16'h0;
        t0 = cyc_n;
        at(30);
        rd(32'h100, 32'h200, 32'h200);
        at(100);
        rd(32'h100, 32'h0, 32'h200);
        $display("test delays done");
        wr(32'h0A8, 32'd2);
        wr(32'h0AC, {16'd20, 16'd20});
        for (int m = 1; m < 9; m++) begin
            wr(32'h0A0, {20'h0, 4'(m), 4'h2, 4'h0});
            vout <= 16'h4;
            t0 = cyc_n;
            at(2 * TP + on_ms[m] * MSC / 2);
            rd(32'h100, 32'h400, 32'h400);
            at(2 * TP + on_ms[m] * MSC + off_ms[m] * MSC / 2);
            rd(32'h100, 32'h0, 32'h400);
            vout <= 16'h0;
            tick(5);
            rd(32'h100, 32'h0, 32'h400);
        end
        $display("test chopping done");
        tick(5);
        print_verdict();
    end
endmodule // cio_top_tb_top
